// File: core/pll_ld_pkg.sv
// Package: register map, field positions, reset values, timing and lock states
package pll_ld_pkg;
  // Register addresses on the serial register port
  localparam logic [5:0] LD_CFG_ADDR = 6'h07;
  localparam logic [5:0] ANA_EN_ADDR = 6'h08;
  localparam logic [5:0] CP_ADDR = 6'h09;
  localparam logic [5:0] STATUS_ADDR = 6'h12;
  // Reset values
  localparam logic [23:0] LD_CFG_RST = 24'h00014d;
  localparam logic [23:0] ANA_EN_RST = 24'hc1beff;
  localparam logic [23:0] CP_RST = 24'h403264;
  // Lock detect register fields
  localparam int LD_THR_LSB = 0;
  localparam int LD_EN_BIT = 3;
  localparam int LD_WIN_DIG_BIT = 6;
  localparam int LD_WIN_LSB = 7;
  // Analog enable register fields
  localparam int ANA_PAD_EN_BIT = 5;
  localparam int ANA_BIAS_BIT = 10;
  localparam int ANA_HF_REF_BIT = 21;
  // Charge pump register fields
  localparam int CP_DN_LSB = 0;
  localparam int CP_UP_LSB = 7;
  localparam int CP_LEAK_LSB = 14;
  localparam int CP_LEAK_DIR_BIT = 22;
  localparam int CP_FIELD_W = 7;
  // Status register field
  localparam int STATUS_LOCK_BIT = 1;
  // Timing: core clock rate and nominal analog window
  localparam int CORE_CLK_MHZ = 50;
  localparam int ANALOG_WIN_NS = 10;
  localparam int ANALOG_WIN_RAW = (ANALOG_WIN_NS * CORE_CLK_MHZ) / 1000;
  localparam int ANALOG_WIN_CYC = (ANALOG_WIN_RAW < 1) ? 1 : ANALOG_WIN_RAW;
  // Arrival difference counter width, saturating
  localparam int DIFF_W = 8;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_COUNT = 2'b01,
    LD_LOCKED = 2'b11
  } lock_state_t;

  // Consecutive in-window arrivals needed for each threshold code
  function automatic logic [CNT_W-1:0] lockThreshold(input logic [2:0] code);
    unique case (code)
      3'h0: lockThreshold = 16'h0005;
      3'h1: lockThreshold = 16'h0020;
      3'h2: lockThreshold = 16'h0060;
      3'h3: lockThreshold = 16'h0100;
      3'h4: lockThreshold = 16'h0200;
      3'h5: lockThreshold = 16'h0800;
      3'h6: lockThreshold = 16'h2000;
      3'h7: lockThreshold = 16'hffff;
    endcase
  endfunction

  // Digital window length in half cycles of the lock detect clock
  function automatic logic [DIFF_W:0] winHalfCycles(input logic [2:0] code);
    winHalfCycles = 9'h001 << code;
  endfunction
endpackage

// File: core/phase_meas_if.sv
// Interface between the arrival comparator and the lock detect control
`timescale 1ns/100ps
`default_nettype none
interface phase_meas_if;
  logic winDigital;
  logic [2:0] winCode;
  logic arrival;
  logic inWin;
  modport meas (input winDigital, input winCode, output arrival, output inWin);
  modport ctrl (output winDigital, output winCode, input arrival, input inWin);
endinterface
`default_nettype wire

// File: core/phase_arrival_cmp.sv
// Arrival time comparator between reference and divided oscillator edges
`timescale 1ns/100ps
`default_nettype none
module phase_arrival_cmp
(
  input wire logic core_clk,
  input wire logic rstSync_n,
  input wire logic refArrive,
  input wire logic divArrive,
  phase_meas_if.meas pm
);
  logic refPend_q;
  logic divPend_q;
  logic [pll_ld_pkg::DIFF_W-1:0] elapsed_q;
  logic [pll_ld_pkg::DIFF_W-1:0] diff_q;
  logic arrival_q;
  logic inWin_q;

  // Pairing: either edge may come first, only the gap counts
  wire both = refArrive && divArrive;
  wire refCloses = refArrive && !divArrive && divPend_q;
  wire divCloses = divArrive && !refArrive && refPend_q;
  wire divMissed = divArrive && !refArrive && divPend_q;
  wire closes = both || refCloses || divCloses;
  wire arrivalD = closes || divMissed;
  wire [pll_ld_pkg::DIFF_W-1:0] diffD = both ? '0 : (divMissed ? '1 : elapsed_q);
  wire startPend = (refArrive || divArrive) && !closes;
  wire elapsedSat = (elapsed_q == '1);

  // Window test in half cycles; the analog one-shot maps to whole core cycles
  wire [pll_ld_pkg::DIFF_W:0] diffHalf = {diffD, 1'b0};
  wire digIn = diffHalf < pll_ld_pkg::winHalfCycles(pm.winCode);
  wire anaIn = diffD < pll_ld_pkg::DIFF_W'(pll_ld_pkg::ANALOG_WIN_CYC);
  wire inWinD = !divMissed && (pm.winDigital ? digIn : anaIn);

  // Pending edge tracking
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      refPend_q <= 1'b0;
      divPend_q <= 1'b0;
      elapsed_q <= '0;
    end
    else
    begin
      refPend_q <= startPend ? refArrive : (refPend_q && !closes);
      divPend_q <= startPend ? divArrive : (divPend_q && !closes);
      elapsed_q <= startPend ? pll_ld_pkg::DIFF_W'(1) : (elapsedSat ? elapsed_q : elapsed_q + 1'b1);
    end
  end

  // Registered result, one pulse per divided arrival
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      arrival_q <= 1'b0;
      inWin_q <= 1'b0;
      diff_q <= '0;
    end
    else
    begin
      arrival_q <= arrivalD;
      inWin_q <= inWinD;
      diff_q <= diffD;
    end
  end

  assign pm.arrival = arrival_q;
  assign pm.inWin = inWin_q;

  a_analog_window: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    arrival_q && !$past(pm.winDigital) |-> inWin_q == (diff_q == '0))
    else $error("analog window result wrong");
  a_digital_window: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    arrival_q && $past(pm.winDigital) && $past(pm.winCode) == 3'h3 |-> inWin_q == (diff_q < 8'h04))
    else $error("digital window length wrong");
  a_either_first: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    (divArrive && !refArrive && !refPend_q && !divPend_q) ##1 (refArrive && !divArrive)
    |=> arrival_q && diff_q == 8'h01)
    else $error("late reference edge not paired");
endmodule
`default_nettype wire

// File: core/pll_lock_detect_control.sv
// Lock detect control, analog enable and charge pump registers of the PLL
`timescale 1ns/100ps
`default_nettype none
module pll_lock_detect_control
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic refArrive,
  input wire logic divArrive,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire logic [5:0] regAddr,
  input wire logic [23:0] regWrData,
  output logic [23:0] regRdData,
  input wire logic padAlwaysOn,
  input wire logic lockDisplayOff,
  input wire logic serialReadActive,
  input wire logic serialDataOut,
  input wire logic chipAddrMismatch,
  output logic lock_or_serial_out_pin,
  output logic lockPinOe_n,
  output logic lockFlag,
  output logic biasEnable,
  output logic highFreqRef,
  output logic [6:0] cpDnGain,
  output logic [6:0] cpUpGain,
  output logic [6:0] cpLeakMag,
  output logic cpLeakDir
);
  logic [1:0] rstSync_q;
  logic [23:0] ldCfg_q;
  logic [23:0] anaEn_q;
  logic [23:0] cpCfg_q;
  logic [23:0] rdData_q;
  logic [pll_ld_pkg::CNT_W-1:0] cnt_q;
  logic [pll_ld_pkg::CNT_W-1:0] cnt_d;
  logic pinOut_q;
  logic pinOe_n_q;
  pll_ld_pkg::lock_state_t state_q;
  pll_ld_pkg::lock_state_t state_d;
  phase_meas_if pm ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  wire rstSync_n = rstSync_q[1];

  // Address decode
  wire wrLd = regWrStrobe && (regAddr == pll_ld_pkg::LD_CFG_ADDR);
  wire wrAna = regWrStrobe && (regAddr == pll_ld_pkg::ANA_EN_ADDR);
  wire wrCp = regWrStrobe && (regAddr == pll_ld_pkg::CP_ADDR);

  // Writable configuration registers
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ldCfg_q <= pll_ld_pkg::LD_CFG_RST;
      anaEn_q <= pll_ld_pkg::ANA_EN_RST;
      cpCfg_q <= pll_ld_pkg::CP_RST;
    end
    else
    begin
      ldCfg_q <= wrLd ? regWrData : ldCfg_q;
      anaEn_q <= wrAna ? regWrData : anaEn_q;
      cpCfg_q <= wrCp ? regWrData : cpCfg_q;
    end
  end

  // Field extraction
  wire ldEnable = ldCfg_q[pll_ld_pkg::LD_EN_BIT];
  wire [2:0] thrCode = ldCfg_q[pll_ld_pkg::LD_THR_LSB +: 3];
  wire padEnable = anaEn_q[pll_ld_pkg::ANA_PAD_EN_BIT];
  assign pm.winDigital = ldCfg_q[pll_ld_pkg::LD_WIN_DIG_BIT];
  assign pm.winCode = ldCfg_q[pll_ld_pkg::LD_WIN_LSB +: 3];

  phase_arrival_cmp u_cmp
  (
    .core_clk(core_clk),
    .rstSync_n(rstSync_n),
    .refArrive(refArrive),
    .divArrive(divArrive),
    .pm(pm)
  );

  // Lock counting; threshold is taken live so a new code acts at once
  wire [pll_ld_pkg::CNT_W-1:0] thr = pll_ld_pkg::lockThreshold(thrCode);
  wire [pll_ld_pkg::CNT_W:0] cntInc = {1'b0, cnt_q} + 17'h00001;
  wire cntFull = cntInc >= {1'b0, thr};
  wire goodHit = pm.arrival && pm.inWin;
  wire badHit = pm.arrival && !pm.inWin;

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!ldEnable)
    begin
      state_d = pll_ld_pkg::LD_IDLE;
      cnt_d = '0;
    end
    else
    begin
      unique case (state_q)
        pll_ld_pkg::LD_IDLE:
          state_d = pll_ld_pkg::LD_COUNT;
        pll_ld_pkg::LD_COUNT:
          if (badHit)
            cnt_d = '0;
          else if (goodHit)
          begin
            cnt_d = cntInc[pll_ld_pkg::CNT_W-1:0];
            if (cntFull)
              state_d = pll_ld_pkg::LD_LOCKED;
          end
        pll_ld_pkg::LD_LOCKED:
          if (badHit)
          begin
            state_d = pll_ld_pkg::LD_COUNT;
            cnt_d = '0;
          end
        default:
          state_d = pll_ld_pkg::LD_IDLE;
      endcase
    end
  end

  // Lock state and count
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      state_q <= pll_ld_pkg::LD_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  // Only the locked code has its upper bit set, so the flag comes straight off a flop
  wire locked = state_q[1];

  // Read mux; unmapped addresses read zero
  wire [23:0] statusWord = 24'(locked) << pll_ld_pkg::STATUS_LOCK_BIT;
  wire [23:0] rdMux = (regAddr == pll_ld_pkg::LD_CFG_ADDR) ? ldCfg_q :
                      (regAddr == pll_ld_pkg::ANA_EN_ADDR) ? anaEn_q :
                      (regAddr == pll_ld_pkg::CP_ADDR) ? cpCfg_q :
                      (regAddr == pll_ld_pkg::STATUS_ADDR) ? statusWord : 24'h000000;

  // Shared pin: driver enable and source; serial data takes over during reads
  wire pinDriven = padEnable && (padAlwaysOn || !chipAddrMismatch);
  wire showLock = !lockDisplayOff && !serialReadActive;
  wire pinD = showLock ? locked : serialDataOut;

  // Registered outputs
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rdData_q <= 24'h000000;
      pinOut_q <= 1'b0;
      pinOe_n_q <= 1'b1;
    end
    else
    begin
      rdData_q <= regRdStrobe ? rdMux : rdData_q;
      pinOut_q <= pinD;
      pinOe_n_q <= !pinDriven;
    end
  end

  assign regRdData = rdData_q;
  assign lock_or_serial_out_pin = pinOut_q;
  assign lockPinOe_n = pinOe_n_q;
  assign lockFlag = locked;
  // Analog controls come straight from register flops
  assign biasEnable = anaEn_q[pll_ld_pkg::ANA_BIAS_BIT];
  assign highFreqRef = anaEn_q[pll_ld_pkg::ANA_HF_REF_BIT];
  assign cpDnGain = cpCfg_q[pll_ld_pkg::CP_DN_LSB +: pll_ld_pkg::CP_FIELD_W];
  assign cpUpGain = cpCfg_q[pll_ld_pkg::CP_UP_LSB +: pll_ld_pkg::CP_FIELD_W];
  assign cpLeakMag = cpCfg_q[pll_ld_pkg::CP_LEAK_LSB +: pll_ld_pkg::CP_FIELD_W];
  assign cpLeakDir = cpCfg_q[pll_ld_pkg::CP_LEAK_DIR_BIT];

  a_thr_reach: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ldEnable && state_q == pll_ld_pkg::LD_COUNT && goodHit && cntInc == {1'b0, thr}
    |=> state_q == pll_ld_pkg::LD_LOCKED)
    else $error("lock not declared at threshold");
  a_no_early_lock: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    state_q == pll_ld_pkg::LD_COUNT && !cntFull |=> !locked)
    else $error("lock declared below threshold");
  a_disable_idle: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    !ldEnable |=> state_q == pll_ld_pkg::LD_IDLE && !lockFlag && cnt_q == '0)
    else $error("detector active while disabled");
  a_pad_off: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    !padEnable |=> lockPinOe_n)
    else $error("pin driven with pad disabled");
  a_shared_release: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    padEnable && !padAlwaysOn && chipAddrMismatch |=> lockPinOe_n)
    else $error("driver kept on for foreign address");
  a_bias_write: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    wrAna |=> biasEnable == $past(regWrData[pll_ld_pkg::ANA_BIAS_BIT]))
    else $error("bias enable not taken from write");
  a_cp_fields: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    wrCp |=> cpUpGain == $past(regWrData[13:7]) && cpDnGain == $past(regWrData[6:0])
    && cpLeakMag == $past(regWrData[20:14]) && cpLeakDir == $past(regWrData[22]))
    else $error("charge pump fields misplaced");
  a_status_read: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    regRdStrobe && regAddr == pll_ld_pkg::STATUS_ADDR |=> regRdData == {22'h000000, $past(locked), 1'b0})
    else $error("status read does not show lock");
  a_read_mux: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    serialReadActive |=> lock_or_serial_out_pin == $past(serialDataOut))
    else $error("pin not handed to serial data during read");
  a_miss_restart: assert property (@(posedge core_clk) disable iff (!rstSync_n)
    ldEnable && badHit |=> cnt_q == '0 && !lockFlag)
    else $error("out of window arrival did not restart count");
endmodule
`default_nettype wire

// File: tb/host_model.sv
// Host controller model driving the register port of the lock detect block
`timescale 1ns/100ps
`default_nettype none
module host_model
#(
  parameter int REF_MHZ = 100
)
(
  input wire logic core_clk,
  output logic regWrStrobe,
  output logic regRdStrobe,
  output logic [5:0] regAddr,
  output logic [23:0] regWrData,
  input wire logic [23:0] regRdData
);
  // Idle port at time zero
  initial
  begin
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    regAddr = 6'h3f;
    regWrData = 24'h000000;
  end

  // Released lines show the inverse, so a stale value never looks valid
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] w;
    w = d;
    if (a == 6'h08)
      w[21] = (REF_MHZ > 200);
    if (a == 6'h09)
      w[22] = 1'b0;
    @(posedge core_clk);
    #1;
    regAddr = a;
    regWrData = w;
    regWrStrobe = 1'b1;
    @(posedge core_clk);
    #1;
    regWrStrobe = 1'b0;
    regAddr = ~a;
    regWrData = ~w;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge core_clk);
    #1;
    regAddr = a;
    regRdStrobe = 1'b1;
    @(posedge core_clk);
    #1;
    regRdStrobe = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the lock detect control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [5:0] a; logic [23:0] d; logic [23:0] m; logic [23:0] e;} reg_row_t;
  typedef struct {logic dig; logic [2:0] w; int gap; logic rf; logic lk;} win_row_t;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic refArrive = 1'b0;
  logic divArrive = 1'b0;
  logic padAlwaysOn = 1'b0;
  logic lockDisplayOff = 1'b0;
  logic serialReadActive = 1'b0;
  logic serialDataOut = 1'b0;
  logic chipAddrMismatch = 1'b0;
  logic regWrStrobe, regRdStrobe, pinData, lockPinOe_n, lockFlag, biasEnable, highFreqRef;
  logic cpLeakDir;
  logic [5:0] regAddr;
  logic [23:0] regWrData, regRdData, rdv;
  logic [6:0] cpDnGain, cpUpGain, cpLeakMag;
  int miscompares = 0;
  int comparisons = 0;
  int thr [7] = '{5, 32, 96, 256, 512, 2048, 8192};
  // Address, write data, read mask, expected read value
  reg_row_t regRows [5] = '{'{6'h09, 24'h1a3c01, 24'hffffff, 24'h1a3c01},
    '{6'h08, 24'he1baff, 24'hffffff, 24'he1baff}, '{6'h07, 24'h0003c8, 24'hffffff, 24'h0003c8},
    '{6'h12, 24'hffffff, 24'h000002, 24'h000000}, '{6'h3f, 24'h5a5a5a, 24'hffffff, 24'h000000}};
  // Digital select, window code, edge gap, reference first, lock expected
  win_row_t winRows [14] = '{'{1'b1, 3'h2, 1, 1'b1, 1'b1}, '{1'b1, 3'h2, 2, 1'b1, 1'b0},
    '{1'b1, 3'h0, 0, 1'b0, 1'b1}, '{1'b1, 3'h1, 1, 1'b1, 1'b0}, '{1'b1, 3'h7, 63, 1'b0, 1'b1},
    '{1'b1, 3'h7, 64, 1'b1, 1'b0}, '{1'b0, 3'h7, 0, 1'b1, 1'b1}, '{1'b0, 3'h7, 1, 1'b0, 1'b0},
    '{1'b1, 3'h3, 3, 1'b0, 1'b1}, '{1'b1, 3'h3, 4, 1'b1, 1'b0}, '{1'b1, 3'h4, 7, 1'b1, 1'b1},
    '{1'b1, 3'h5, 15, 1'b0, 1'b1}, '{1'b1, 3'h6, 32, 1'b1, 1'b0}, '{1'b1, 3'h2, 1, 1'b0, 1'b1}};

  always #10 core_clk = ~core_clk;

  host_model #(.REF_MHZ(250)) host_model_i (.core_clk(core_clk), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

  pll_lock_detect_control pll_lock_detect_control_i (.core_clk(core_clk), .arst_n(arst_n),
    .refArrive(refArrive), .divArrive(divArrive), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .padAlwaysOn(padAlwaysOn), .lockDisplayOff(lockDisplayOff),
    .serialReadActive(serialReadActive), .serialDataOut(serialDataOut),
    .chipAddrMismatch(chipAddrMismatch), .lock_or_serial_out_pin(pinData),
    .lockPinOe_n(lockPinOe_n), .lockFlag(lockFlag), .biasEnable(biasEnable),
    .highFreqRef(highFreqRef), .cpDnGain(cpDnGain), .cpUpGain(cpUpGain),
    .cpLeakMag(cpLeakMag), .cpLeakDir(cpLeakDir));

  // Inputs always move a fixed 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One reference and divided edge pair; trailing idle lets the lock flag settle
  task automatic arr(input int gap, input logic rf);
    refArrive = (gap == 0) | rf;
    divArrive = (gap == 0) | !rf;
    tick(1);
    if (gap > 0)
    begin
      refArrive = (gap == 1) & !rf;
      divArrive = (gap == 1) & rf;
      if (gap > 1)
      begin
        tick(gap - 1);
        refArrive = !rf;
        divArrive = rf;
      end
      tick(1);
    end
    refArrive = 1'b0;
    divArrive = 1'b0;
    tick(2);
  endtask

  // Disable then enable, so every run starts from an empty count
  task automatic arm(input logic [2:0] t, input logic dig, input logic [2:0] w);
    host_model_i.wr(6'h07, {14'h0, w, dig, 2'b00, 1'b0, t});
    host_model_i.wr(6'h07, {14'h0, w, dig, 2'b00, 1'b1, t});
    tick(2);
  endtask

  initial
  begin
    #1900000;
    miscompares++;
    results();
  end

  initial
  begin
    tick(12);
    arst_n = 1'b1;
    tick(3);
    chk({biasEnable, highFreqRef, cpLeakDir, cpLeakMag, cpUpGain, cpDnGain}, 24'ha03264);
    host_model_i.rd(6'h07, rdv);
    chk(rdv, 24'h00014d);
    host_model_i.rd(6'h08, rdv);
    chk(rdv, 24'hc1beff);
    host_model_i.rd(6'h09, rdv);
    chk(rdv, 24'h403264);
    $display("test reset done");
    foreach (regRows[i])
    begin
      host_model_i.wr(regRows[i].a, regRows[i].d);
      host_model_i.rd(regRows[i].a, rdv);
      chk(rdv & regRows[i].m, regRows[i].e);
      if (regRows[i].a == 6'h09)
        chk({cpLeakDir, cpLeakMag, cpUpGain, cpDnGain}, {regRows[i].d[22], regRows[i].d[20:0]});
      if (regRows[i].a == 6'h08)
        chk({biasEnable, highFreqRef}, {regRows[i].d[10], regRows[i].d[21]});
    end
    $display("test registers done");
    foreach (winRows[i])
    begin
      arm(3'h0, winRows[i].dig, winRows[i].w);
      repeat (5) arr(winRows[i].gap, winRows[i].rf);
      chk(24'(lockFlag), 24'(winRows[i].lk));
    end
    $display("test windows done");
    // A miss inside a run must restart the count
    arm(3'h0, 1'b1, 3'h2);
    repeat (4) arr(1, 1'b1);
    arr(2, 1'b0);
    repeat (4) arr(0, 1'b1);
    chk(24'(lockFlag), 24'h0);
    arr(0, 1'b0);
    chk(24'(lockFlag), 24'h1);
    host_model_i.wr(6'h07, 24'h000140);
    tick(2);
    chk(24'(lockFlag), 24'h0);
    repeat (6) arr(0, 1'b1);
    chk(24'(lockFlag), 24'h0);
    $display("test restart and disable done");
    for (int c = 0; c < 7; c++)
    begin
      arm(3'(c), 1'b1, 3'h2);
      repeat (thr[c] - 1) arr(1, 1'b1);
      chk(24'(lockFlag), 24'h0);
      arr(1, 1'b1);
      chk(24'(lockFlag), 24'h1);
    end
    host_model_i.rd(6'h12, rdv);
    chk(rdv & 24'h000002, 24'h000002);
    $display("test thresholds done");
    for (int k = 0; k < 8; k++)
    begin
      {lockDisplayOff, serialReadActive, serialDataOut} = 3'(k);
      tick(1);
      chk(24'(pinData), 24'((k < 2) ? 1 : k % 2));
    end
    for (int k = 0; k < 8; k++)
    begin
      host_model_i.wr(6'h08, k[2] ? 24'hc1beff : 24'hc1bedf);
      {padAlwaysOn, chipAddrMismatch} = 2'(k);
      tick(1);
      chk(24'(lockPinOe_n), 24'(!(k[2] && (k[1] || !k[0]))));
    end
    $display("test pin done");
    arr(2, 1'b1);
    chk(24'(lockFlag), 24'h0);
    host_model_i.rd(6'h12, rdv);
    chk(rdv & 24'h000002, 24'h000000);
    $display("test miss done");
    // Mid-run reset must bring pin, flag and read data back to their idle values
    arst_n = 1'b0;
    tick(2);
    chk({21'h0, pinData, lockPinOe_n, lockFlag}, 24'h000002);
    chk(regRdData, 24'h000000);
    arst_n = 1'b1;
    tick(3);
    host_model_i.rd(6'h07, rdv);
    chk(rdv, 24'h00014d);
    $display("test mid reset done");
    results();
  end
endmodule
`default_nettype wire
